/* core/dpot_defines.svh */
`ifndef DPOT_DEFINES_SVH
`define DPOT_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define DPOT_CLK_MHZ         50
`define DPOT_EE_STORE_MS     15
`define DPOT_EE_STORE_CYC    (`DPOT_EE_STORE_MS * 1000 * `DPOT_CLK_MHZ)

// ****************************************
// Link framing
// ****************************************
`define DPOT_DEV_ADDR        7'h20
`define DPOT_CNT_ACK         4'h8
`define DPOT_CNT_END         4'h9
`define DPOT_RB_HI_BYTE      8'h00

// ****************************************
// Command word fields
// ****************************************
`define DPOT_CODE_MSB        15
`define DPOT_CODE_LSB        12
`define DPOT_ADDR_MSB        11
`define DPOT_ADDR_LSB        8
`define DPOT_DATA_MSB        7
`define DPOT_DATA_LSB        0

// ****************************************
// Command codes
// ****************************************
`define DPOT_CMD_NOP         4'h0
`define DPOT_CMD_WR_WIPER    4'h1
`define DPOT_CMD_WR_PRE      4'h2
`define DPOT_CMD_READBACK    4'h3
`define DPOT_CMD_COPY        4'h7
`define DPOT_CMD_WR_EE       4'h8
`define DPOT_CMD_SW_RESET    4'hb
`define DPOT_CMD_SHUTDOWN    4'hc

// ****************************************
// Channel addressing and readback select
// ****************************************
`define DPOT_ADDR_ALL_BIT    3
`define DPOT_MEM_CH1         4'h0
`define DPOT_MEM_CH2         4'h2
`define DPOT_RB_PRE          2'h0
`define DPOT_RB_EE           2'h1
`define DPOT_RB_CTRL         2'h2
`define DPOT_RB_WIPER        2'h3

// ****************************************
// Reset values
// ****************************************
`define DPOT_EE_INIT         8'h80

`endif

/* core/dpot_pkg.sv */
package dpot_pkg;

  // ****************************************
  // Link phases
  // ****************************************
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_WRITE,
    PH_READ
  } dpot_phase_e;

  typedef logic [15:0] dpot_word_t;
  typedef logic [7:0]  dpot_byte_t;

endpackage

/* core/dpot_sync.sv */
`timescale 1ns/1ns

module dpot_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // Asynchronous pins and their filtered levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;

  // Idle bus floats high, so everything resets to one
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // Change accepted only once stages two and three agree
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          lvl_r[g] <= 1'b1;
        end else if (s2_r[g] == s3_r[g]) begin
          lvl_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  assign level = lvl_r;

endmodule

/* core/dpot_cmd_unit.sv */
// Behaviour
// - Store locks device, no acknowledge ~15 ms
// - Wiper position follows wiper setting register
// - Stored value reloads wiper at power-up
// - Word: code, channel address, eight data
// - Shifted MSB first; code selects operation
// - 128-tap variant ignores data bit zero except for preload
// - Code 1 writes wiper directly
// - Code 2 writes preload, wiper untouched
// - Preload holds pending value apart
// - Code 3 selects readback: preload, EEPROM, control or wiper
// - Code 7: bit0 stores, else recalls
// - Separate command writes EEPROM directly
// - Code 0 nothing, 11 reset, 12 shutdown
// - Address: all, channel one, channel two
// - Works at 100 kHz and 400 kHz
// - No 10-bit or general call
// - Acknowledge on ninth pulse when matched
// - Nine pulses per byte, SDA stable high
// - Command word as two acknowledged bytes
// - No second byte after first nack
`timescale 1ns/1ns
`include "dpot_defines.svh"

module dpot_cmd_unit #(
  parameter int unsigned EE_STORE_CYC = `DPOT_EE_STORE_CYC,
  parameter bit          POS_256      = 1'b1,
  parameter logic [6:0]  DEV_ADDR     = `DPOT_DEV_ADDR,
  parameter logic [7:0]  EE_INIT      = `DPOT_EE_INIT
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Two-wire link
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Potentiometer state
  output logic [7:0]      channel_one_wiper,
  output logic [7:0]      channel_two_wiper,
  output logic [1:0]      shutdown,
  output logic            store_busy
);

  localparam int CW = $clog2(EE_STORE_CYC + 1);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] fix_lsb(input logic [7:0] d);
    fix_lsb = POS_256 ? d : {d[7:1], 1'b0};
  endfunction

  function automatic logic [1:0] wiper_mask(input logic [3:0] a);
    if (a[`DPOT_ADDR_ALL_BIT]) begin
      wiper_mask = 2'h3;
    end else if (a[0]) begin
      wiper_mask = 2'h2;
    end else begin
      wiper_mask = 2'h1;
    end
  endfunction

  function automatic logic [1:0] mem_mask(input logic [3:0] a);
    if (a[`DPOT_ADDR_ALL_BIT]) begin
      mem_mask = 2'h3;
    end else if (a == `DPOT_MEM_CH1) begin
      mem_mask = 2'h1;
    end else if (a == `DPOT_MEM_CH2) begin
      mem_mask = 2'h2;
    end else begin
      mem_mask = 2'h0;
    end
  endfunction

  // ****************************************
  // Pin sampling
  // ****************************************
  logic scl_f;
  logic sda_f;
  logic scl_d_r;
  logic sda_d_r;

  dpot_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .async_in ({scl_in, sda_in}),
    .level    ({scl_f, sda_f})
  );

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  wire scl_rise  = scl_f & ~scl_d_r;
  wire scl_fall  = ~scl_f & scl_d_r;
  wire start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
  wire stop_det  = scl_f & scl_d_r & ~sda_d_r & sda_f;

  // ****************************************
  // Link engine
  // ****************************************
  dpot_pkg::dpot_phase_e phase_r;
  logic [3:0]            cnt_r;
  dpot_pkg::dpot_byte_t  shift_r;
  dpot_pkg::dpot_byte_t  cmd_hi_r;
  dpot_pkg::dpot_byte_t  tx_r;
  dpot_pkg::dpot_word_t  word_r;
  logic                  hi_r;
  logic                  drive_r;
  logic                  mack_r;
  logic                  rd_idx_r;
  logic                  exec_r;
  logic [CW-1:0]         busy_cnt_r;
  logic [7:0]            rb_data;

  wire addr_hit = (shift_r[7:1] == DEV_ADDR) && !store_busy;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      phase_r  <= dpot_pkg::PH_IDLE;
      cnt_r    <= 4'h0;
      shift_r  <= 8'h00;
      cmd_hi_r <= 8'h00;
      tx_r     <= 8'h00;
      word_r   <= 16'h0000;
      hi_r     <= 1'b0;
      drive_r  <= 1'b0;
      mack_r   <= 1'b1;
      rd_idx_r <= 1'b0;
      exec_r   <= 1'b0;
    end else begin
      exec_r <= 1'b0;
      if (start_det) begin
        phase_r <= dpot_pkg::PH_ADDR;
        cnt_r   <= 4'h0;
        drive_r <= 1'b0;
        hi_r    <= 1'b0;
      end else if (stop_det) begin
        phase_r <= dpot_pkg::PH_IDLE;
        drive_r <= 1'b0;
      end else if (scl_rise && phase_r != dpot_pkg::PH_IDLE) begin
        if (cnt_r < `DPOT_CNT_ACK) begin
          shift_r <= {shift_r[6:0], sda_f};
        end else begin
          mack_r <= sda_f;
        end
        cnt_r <= cnt_r + 4'h1;
      end else if (scl_fall) begin
        if (cnt_r == `DPOT_CNT_END) begin
          cnt_r <= 4'h0;
        end
        case (phase_r)
          dpot_pkg::PH_ADDR: begin
            if (cnt_r == `DPOT_CNT_ACK) begin
              if (addr_hit) begin
                drive_r <= 1'b1;
              end else begin
                phase_r <= dpot_pkg::PH_IDLE;
              end
            end else if (cnt_r == `DPOT_CNT_END) begin
              if (shift_r[0]) begin
                phase_r  <= dpot_pkg::PH_READ;
                rd_idx_r <= 1'b0;
                tx_r     <= `DPOT_RB_HI_BYTE;
                // Pull low when the first byte's MSB is zero
                drive_r  <= (`DPOT_RB_HI_BYTE < 8'h80);
              end else begin
                phase_r <= dpot_pkg::PH_WRITE;
                drive_r <= 1'b0;
              end
            end
          end
          dpot_pkg::PH_WRITE: begin
            if (cnt_r == `DPOT_CNT_ACK) begin
              if (store_busy) begin
                phase_r <= dpot_pkg::PH_IDLE;
              end else begin
                drive_r <= 1'b1;
                hi_r    <= ~hi_r;
                if (hi_r) begin
                  exec_r <= 1'b1;
                  word_r <= {cmd_hi_r, shift_r};
                end else begin
                  cmd_hi_r <= shift_r;
                end
              end
            end else if (cnt_r == `DPOT_CNT_END) begin
              drive_r <= 1'b0;
            end
          end
          dpot_pkg::PH_READ: begin
            if (cnt_r == `DPOT_CNT_ACK) begin
              drive_r <= 1'b0;
            end else if (cnt_r == `DPOT_CNT_END) begin
              if (!mack_r && !rd_idx_r) begin
                rd_idx_r <= 1'b1;
                tx_r     <= rb_data;
                drive_r  <= ~rb_data[7];
              end else begin
                phase_r <= dpot_pkg::PH_IDLE;
              end
            end else if (cnt_r != 4'h0) begin
              drive_r <= ~tx_r[6];
              tx_r    <= {tx_r[6:0], 1'b0};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Open drain: only ever pull low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_r;

  // ****************************************
  // Command decode
  // ****************************************
  wire [3:0] cmd_code = word_r[`DPOT_CODE_MSB:`DPOT_CODE_LSB];
  wire [3:0] cmd_addr = word_r[`DPOT_ADDR_MSB:`DPOT_ADDR_LSB];
  wire [7:0] cmd_data = word_r[`DPOT_DATA_MSB:`DPOT_DATA_LSB];
  wire [1:0] wmask    = wiper_mask(cmd_addr);
  wire [1:0] mmask    = mem_mask(cmd_addr);

  // NO_OPERATION and undecoded codes match nothing
  wire do_wr_wiper = exec_r && (cmd_code == `DPOT_CMD_WR_WIPER);
  wire do_wr_pre   = exec_r && (cmd_code == `DPOT_CMD_WR_PRE);
  wire do_rb_sel   = exec_r && (cmd_code == `DPOT_CMD_READBACK);
  wire do_copy     = exec_r && (cmd_code == `DPOT_CMD_COPY);
  wire do_to_ee    = do_copy && cmd_data[0];
  wire do_to_wiper = do_copy && !cmd_data[0];
  wire do_wr_ee    = exec_r && (cmd_code == `DPOT_CMD_WR_EE);
  wire do_sw_reset = exec_r && (cmd_code == `DPOT_CMD_SW_RESET);
  wire do_sd       = exec_r && (cmd_code == `DPOT_CMD_SHUTDOWN);
  wire store_start = (do_to_ee && |wmask) || (do_wr_ee && |mmask);

  // ****************************************
  // Channel registers
  // ****************************************
  logic [7:0] wiper_r [2];
  logic [7:0] pre_r   [2];
  // Nonvolatile: untouched by reset, so a reset stands in for power-up
  logic [7:0] ee_r    [2] = '{EE_INIT, EE_INIT};
  logic [1:0] sd_r;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      always_ff @(posedge clk_sys) begin
        if (!nrst || do_sw_reset) begin
          wiper_r[ch] <= ee_r[ch];
          pre_r[ch]   <= ee_r[ch];
          sd_r[ch]    <= 1'b0;
        end else begin
          if (do_wr_wiper && wmask[ch]) begin
            // Low bit dropped on 128 taps
            wiper_r[ch] <= fix_lsb(cmd_data);
          end else if (do_to_wiper && wmask[ch]) begin
            wiper_r[ch] <= ee_r[ch];
          end
          if (do_wr_pre && wmask[ch]) begin
            pre_r[ch] <= cmd_data;
          end
          if (do_sd && wmask[ch]) begin
            sd_r[ch] <= cmd_data[0];
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (nrst) begin
          if (do_to_ee && wmask[ch]) begin
            ee_r[ch] <= wiper_r[ch];
          end else if (do_wr_ee && mmask[ch]) begin
            ee_r[ch] <= fix_lsb(cmd_data);
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Store timer
  // ****************************************
  // Lock window counted from store start
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_cnt_r <= '0;
    end else if (store_start) begin
      busy_cnt_r <= CW'(EE_STORE_CYC);
    end else if (busy_cnt_r != '0) begin
      busy_cnt_r <= busy_cnt_r - CW'(1);
    end
  end

  assign store_busy = (busy_cnt_r != '0);

  // ****************************************
  // Readback
  // ****************************************
  logic [1:0] rb_sel_r;
  logic [3:0] rb_addr_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rb_sel_r  <= `DPOT_RB_WIPER;
      rb_addr_r <= 4'h0;
    end else if (do_rb_sel) begin
      rb_sel_r  <= cmd_data[1:0];
      rb_addr_r <= cmd_addr;
    end
  end

  wire rb_wch = rb_addr_r[0];
  wire rb_mch = (rb_addr_r == `DPOT_MEM_CH2);

  assign rb_data = (rb_sel_r == `DPOT_RB_EE)    ? fix_lsb(ee_r[rb_mch]) :
                   (rb_sel_r == `DPOT_RB_WIPER) ? fix_lsb(wiper_r[rb_wch]) :
                   (rb_sel_r == `DPOT_RB_PRE)   ? pre_r[rb_wch] : 8'h00;

  // ****************************************
  // Outputs
  // ****************************************
  // Wiper tracks its register
  assign channel_one_wiper = wiper_r[0];
  assign channel_two_wiper = wiper_r[1];
  assign shutdown          = sd_r;

endmodule

/* test/dpot_cmd_monitor.sv */
`timescale 1ns/1ns
module dpot_cmd_monitor #(
  parameter int unsigned EE_STORE_CYC = 32'h000b_71b0
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Two-wire link
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       sda_out,
  input  wire logic       sda_oe_n,
  // Potentiometer state
  input  wire logic [7:0] channel_one_wiper,
  input  wire logic [7:0] channel_two_wiper,
  input  wire logic [1:0] shutdown,
  input  wire logic       store_busy
);
  // Length of the current lock run
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;

  assign busy_cnt_nxt = store_busy ? busy_cnt_r + 32'h0000_0001 : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_drive_low;
    !sda_oe_n [*8];
  endsequence

  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("device moved data while clock high");
  a_ack_held: assert property ($fell(sda_oe_n) |-> s_drive_low)
    else $error("device pull too short");
  a_lock_quiet: assert property (store_busy && $past(store_busy, 40) |-> sda_oe_n)
    else $error("device answered while locked");
  a_lock_length: assert property ($fell(store_busy) |->
    busy_cnt_r >= EE_STORE_CYC - 1 && busy_cnt_r <= EE_STORE_CYC + 1)
    else $error("lock length wrong");
  a_lock_at_cmd: assert property ($rose(store_busy) |-> !sda_oe_n)
    else $error("lock started outside a command");
  a_wiper_at_cmd: assert property (
    $changed(channel_one_wiper) || $changed(channel_two_wiper) |-> !sda_oe_n)
    else $error("wiper moved outside a command");
  a_shut_at_cmd: assert property ($changed(shutdown) |-> !sda_oe_n)
    else $error("shutdown moved outside a command");
  a_pull_low_only: assert property (sda_out == 1'b0)
    else $error("data driven high");
endmodule

bind dpot_cmd_unit dpot_cmd_monitor #(
  .EE_STORE_CYC(EE_STORE_CYC)
) dpot_cmd_monitor_inst (
  .clk_sys           (clk_sys),
  .nrst              (nrst),
  .scl_in            (scl_in),
  .sda_in            (sda_in),
  .sda_out           (sda_out),
  .sda_oe_n          (sda_oe_n),
  .channel_one_wiper (channel_one_wiper),
  .channel_two_wiper (channel_two_wiper),
  .shutdown          (shutdown),
  .store_busy        (store_busy)
);

/* test/dpot_host.sv */
`timescale 1ns/1ns
module dpot_host (
  // Clock
  input  wire logic clk_sys,
  // Bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // Half period of eight clocks: the pin sampler needs that margin
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic start();
    sda_pull <= 1'b0;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(8);
    sda_pull <= 1'b1;
    wait_clk(8);
    scl <= 1'b0;
  endtask

  task automatic stop();
    wait_clk(4);
    sda_pull <= 1'b1;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(8);
    sda_pull <= 1'b0;
    wait_clk(8);
  endtask

  task automatic xbit(input logic b, output logic r);
    wait_clk(4);
    sda_pull <= ~b;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(8);
    r = sda;
    scl <= 1'b0;
  endtask

  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic k);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(a, k);
  endtask
endmodule

/* test/tb.sv */
`timescale 1ns/1ns
module tb;
  localparam logic [6:0] A = 7'h20;
  localparam logic [6:0] B = 7'h21;
  logic       clk_sys;
  logic       nrst;
  logic       scl;
  logic       sda_pull;
  logic       oe_n_a;
  logic       oe_n_b;
  logic [7:0] w1_a;
  logic [7:0] w2_a;
  logic [7:0] w1_b;
  logic [1:0] shdn_a;
  logic       busy_a;
  int         num_errors;
  int         comparisons;
  // Pull-up: high unless a party pulls low
  wire        sda = ~sda_pull & oe_n_a & oe_n_b;

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  dpot_host dpot_host_inst (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  dpot_cmd_unit #(.EE_STORE_CYC(32'h0000_00c8)) dpot_cmd_unit_inst (
    .clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe_n(oe_n_a), .channel_one_wiper(w1_a), .channel_two_wiper(w2_a),
    .shutdown(shdn_a), .store_busy(busy_a));
  dpot_cmd_unit #(.EE_STORE_CYC(32'h0000_00c8), .POS_256(1'b0), .DEV_ADDR(B)) dpot_cmd_unit_inst2 (
    .clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe_n(oe_n_b), .channel_one_wiper(w1_b), .channel_two_wiper(),
    .shutdown(), .store_busy());

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] w, output logic nak);
    logic [7:0] q;
    logic       k1;
    logic       k2;
    dpot_host_inst.start();
    dpot_host_inst.xbyte({a, 1'b0}, 1'b1, q, nak);
    if (!nak) begin
      dpot_host_inst.xbyte(w[15:8], 1'b1, q, k1);
      dpot_host_inst.xbyte(w[7:0], 1'b1, q, k2);
      check({k1, k2}, 16'h0000);
    end
    dpot_host_inst.stop();
  endtask

  task automatic cmd(input logic [6:0] a, input logic [15:0] w);
    logic nak;
    wr(a, w, nak);
    check(nak, 1'b0);
  endtask

  task automatic rb(input logic [6:0] a, input logic [3:0] ch, input logic [1:0] sel,
                    input logic [7:0] exp);
    logic [7:0] q;
    logic       k;
    cmd(a, {4'h3, ch, 6'h00, sel});
    dpot_host_inst.start();
    dpot_host_inst.xbyte({a, 1'b1}, 1'b1, q, k);
    dpot_host_inst.xbyte(8'hff, 1'b0, q, k);
    check(q, 8'h00);
    dpot_host_inst.xbyte(8'hff, 1'b1, q, k);
    check(q, exp);
    dpot_host_inst.stop();
  endtask

  task automatic poll(input logic [6:0] a);
    logic [7:0] q;
    logic       k;
    int         n;
    n = 0;
    k = 1'b1;
    while (k && n < 40) begin
      dpot_host_inst.start();
      dpot_host_inst.xbyte({a, 1'b0}, 1'b1, q, k);
      dpot_host_inst.stop();
      n++;
    end
    check(k, 1'b0);
    check(n > 1, 1'b1);
  endtask

  task automatic t_write();
    check({w1_a, w2_a}, 16'h8080);
    cmd(A, 16'h1035);
    cmd(A, 16'h11ca);
    check({w1_a, w2_a}, 16'h35ca);
    cmd(A, 16'h185a);
    check({w1_a, w2_a}, 16'h5a5a);
    rb(A, 4'h0, 2'h3, 8'h5a);
    cmd(A, 16'h2177);
    check(w2_a, 8'h5a);
    rb(A, 4'h1, 2'h0, 8'h77);
    rb(A, 4'h0, 2'h1, 8'h80);
    rb(A, 4'h0, 2'h2, 8'h00);
    $display("test write done");
  endtask

  task automatic t_undef();
    logic [3:0] codes [9] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha, 4'hd, 4'he, 4'hf};
    foreach (codes[i]) begin
      cmd(A, {codes[i], 4'h8, 8'h00});
      check({w1_a, w2_a, shdn_a, busy_a}, 19'h2d2d0);
    end
    rb(A, 4'h0, 2'h1, 8'h80);
    $display("test undefined done");
  endtask

  task automatic t_store();
    cmd(A, 16'h103c);
    cmd(A, 16'h7001);
    check(busy_a, 1'b1);
    poll(A);
    rb(A, 4'h0, 2'h1, 8'h3c);
    cmd(A, 16'h1011);
    cmd(A, 16'h7000);
    check(w1_a, 8'h3c);
    cmd(A, 16'h8266);
    poll(A);
    check(w2_a, 8'h5a);
    rb(A, 4'h2, 2'h1, 8'h66);
    cmd(A, 16'h1144);
    cmd(A, 16'hb000);
    check(w2_a, 8'h66);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check({w1_a, w2_a}, 16'h3c66);
    $display("test store done");
  endtask

  task automatic t_misc();
    logic       nak;
    logic [7:0] q;
    cmd(A, 16'hc101);
    check(shdn_a, 2'h2);
    cmd(A, 16'hc801);
    check(shdn_a, 2'h3);
    cmd(A, 16'hc800);
    check(shdn_a, 2'h0);
    wr(7'h55, 16'h1000, nak);
    check(nak, 1'b1);
    wr(7'h00, 16'h1000, nak);
    check(nak, 1'b1);
    wr(7'h78, 16'h1000, nak);
    check({nak, w1_a}, 9'h13c);
    dpot_host_inst.start();
    dpot_host_inst.xbyte({A, 1'b1}, 1'b1, q, nak);
    dpot_host_inst.xbyte(8'hff, 1'b1, q, nak);
    dpot_host_inst.xbyte(8'hff, 1'b1, q, nak);
    check(q, 8'hff);
    dpot_host_inst.stop();
    cmd(B, 16'h105b);
    check(w1_b, 8'h5a);
    rb(B, 4'h0, 2'h3, 8'h5a);
    $display("test misc done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    num_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_write();
    t_undef();
    t_store();
    t_misc();
    stop_test();
  end

  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end
endmodule
